//--- hw/clk_gen_pkg.sv
// Package for the clock generator control block: register map, field
// positions, reset values and timing counts.
// Assumes a 25 MHz bus clock and a classic Wishbone register port.
package clk_gen_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_MULT = 8'h04;
  localparam logic [7:0] ADDR_TRIM = 8'h08;
  localparam logic [7:0] ADDR_DIVIDER = 8'h0c;
  localparam logic [7:0] ADDR_STAGE = 8'h10;
  localparam logic [7:0] ADDR_OPTION = 8'h14;

  // ----------------------------------------------------------------
  // Control and option register field positions
  // ----------------------------------------------------------------
  localparam int BIT_EGS = 0;
  localparam int BIT_EGON = 1;
  localparam int BIT_IGS = 2;
  localparam int BIT_IGON = 3;
  localparam int BIT_SEL = 4;
  localparam int BIT_MON = 5;
  localparam int BIT_RUN_STOP = 0;

  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [6:0] MULT_RST = 7'h15;
  localparam logic [7:0] TRIM_RST = 8'h80;
  localparam logic [3:0] DIV_MAX = 4'h9;

  // ----------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------
  localparam logic [12:0] EXT_START_CYCLES = 13'h1000;
  localparam logic [4:0] INT_SETTLE_EDGES = 5'h10;
  localparam int MON_TIMEOUT_NS = 2000;
  localparam int CLK_PERIOD_NS = 40;
  localparam logic [7:0] MON_TIMEOUT_CYC =
    8'(MON_TIMEOUT_NS / CLK_PERIOD_NS);

  // Control bits of the generator
  typedef struct packed {
    logic mon_en;
    logic clk_sel;
    logic igon;
    logic igs;
    logic egon;
    logic egs;
  } ctrl_type;

  localparam ctrl_type CTRL_RST = '{mon_en: 1'b0, clk_sel: 1'b0,
    igon: 1'b1, igs: 1'b0, egon: 1'b0, egs: 1'b0};

  // Settings handed to the analog oscillator
  typedef struct packed {
    logic [6:0] mult;
    logic [7:0] trim;
    logic [3:0] divider;
    logic [7:0] stage;
  } osc_cfg_type;

endpackage

//--- hw/clk_gen_ctrl.sv
// Clock generator control: source select, enable/stable interlocks,
// clock monitor, external start-up count and oscillator settings.
// Assumes both oscillator clocks arrive as asynchronous pins, far
// slower than the bus clock, and software on a Wishbone classic bus.
//
// Functional notes
// - Select 1 routes external clock, 0 internal.
// - Select changes need target on and stable.
// - Internal loss or internal off forces select.
// - External loss, external off, reset clear select.
// - Internal off only when select set, monitor off.
// - Monitor, select clear or reset hold internal on.
// - Internal stable read-only, set when settled.
// - Loss, off, mult/trim write, stop clear stable.
// - External off only when select, monitor clear.
// - Monitor or select force external on.
// - External stable after 4096 external cycles.
// - Loss, off, stop or reset clear external stable.
// - Multiplier zero acts as one.
// - Monitor on blocks multiplier and trim writes.
// - Reset loads multiplier with 21.
// - Trim steps oscillator capacitance.
// - Reset loads trim mid-range.
// - Divider saturates at nine, loop drives it.
// - Loop drives stage, writes blocked while on.
// - Stage step lengthens oscillator period.
// - Reset leaves divider and stage alone.
// - Monitor enable watches both clocks.
// - Stop without run option halts clocks.
`timescale 1ns/10ps
module clk_gen_ctrl (
  input wire logic clk_i, // Bus clock, 25 MHz
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic cyc_i, // Wishbone cycle
  input wire logic stb_i, // Wishbone strobe
  input wire logic we_i, // Wishbone write enable
  input wire logic [7:0] adr_i, // Wishbone byte address
  input wire logic [3:0] sel_i, // Wishbone byte selects
  input wire logic [31:0] dat_i, // Wishbone write data
  output logic [31:0] dat_o, // Wishbone read data
  output logic ack_o, // Wishbone acknowledge
  input wire logic internal_clock_i, // Internal oscillator clock
  input wire logic external_clock_i, // External oscillator clock
  input wire logic stop_i, // Stop mode request
  input wire logic [3:0] loop_div_i, // Loop filter divider value
  input wire logic [7:0] loop_stage_i, // Loop filter stage value
  output logic osc_output_clock_o, // Selected oscillator clock
  output logic clocks_halt_o, // Bus and timebase clocks held low
  output logic internal_enable_o, // Internal generator enable
  output logic external_enable_o, // External generator enable
  output clk_gen_pkg::osc_cfg_type osc_cfg_o // Oscillator settings
);
  import clk_gen_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Zero multiplier behaves as one
  function automatic logic [6:0] eff_mult(input logic [6:0] m);
    eff_mult = (m == 7'h00) ? 7'h01 : m;
  endfunction

  // Divider codes above nine act as nine
  function automatic logic [3:0] eff_div(input logic [3:0] d);
    eff_div = (d > DIV_MAX) ? DIV_MAX : d;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ctrl_type ctrl_q; // Control bits
  ctrl_type ctrl_d; // Next control bits
  logic [6:0] mult_q; // Multiplier factor
  logic [7:0] trim_q; // Trim factor
  logic [3:0] div_q; // Divider count, no reset
  logic [7:0] stage_q; // Stage count, no reset
  logic run_stop_q; // Keep oscillators running in stop
  logic ack_q; // Bus acknowledge
  logic [31:0] rdat_q; // Read data register
  logic [2:0] isync_q; // Internal clock synchroniser
  logic [2:0] esync_q; // External clock synchroniser
  logic ilev_q; // Filtered internal level
  logic elev_q; // Filtered external level
  logic [7:0] iidle_q; // Cycles since internal edge
  logic [7:0] eidle_q; // Cycles since external edge
  logic [4:0] icnt_q; // Internal settle edge count
  logic [12:0] ecnt_q; // External start-up cycle count
  logic out_clk_q; // Output clock register

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire req = cyc_i & stb_i;
  wire wr = req & we_i & sel_i[0] & ack_q;
  wire wr_ctrl = wr & (adr_i == ADDR_CONTROL);
  wire wr_mult = wr & (adr_i == ADDR_MULT);
  wire wr_trim = wr & (adr_i == ADDR_TRIM);
  wire wr_div = wr & (adr_i == ADDR_DIVIDER);
  wire wr_stage = wr & (adr_i == ADDR_STAGE);
  wire wr_opt = wr & (adr_i == ADDR_OPTION);
  wire [7:0] wdat = dat_i[7:0];

  // ----------------------------------------------------------------
  // Clock monitor
  // ----------------------------------------------------------------
  wire iedge = (isync_q[2] == isync_q[1]) & isync_q[1] & ~ilev_q;
  wire eedge = (esync_q[2] == esync_q[1]) & esync_q[1] & ~elev_q;
  wire iidle = (iidle_q >= MON_TIMEOUT_CYC);
  wire eidle = (eidle_q >= MON_TIMEOUT_CYC);
  wire int_lost = ctrl_q.mon_en & iidle;
  wire ext_lost = ctrl_q.mon_en & eidle;
  wire halt = stop_i & ~run_stop_q;
  wire igs_clr = int_lost | ~ctrl_q.igon | wr_mult | wr_trim | halt;

  // ----------------------------------------------------------------
  // Interlocked control bits
  // ----------------------------------------------------------------
  wire sw_sel = wdat[BIT_SEL];
  wire sw_igon = wdat[BIT_IGON];
  wire sw_egon = wdat[BIT_EGON];
  wire sw_mon = wdat[BIT_MON];
  // Select may rise only with external on and stable
  wire sel_set_ok = ctrl_q.egon & ctrl_q.egs;
  // Select may fall only with internal on and stable
  wire sel_clr_ok = ctrl_q.igon & ctrl_q.igs;
  wire igon_clr_ok = ctrl_q.clk_sel & ~ctrl_q.mon_en;
  wire egon_clr_ok = ~ctrl_q.clk_sel & ~ctrl_q.mon_en;
  wire mon_set_ok = ctrl_q.igon & ctrl_q.egon & ctrl_q.igs
    & ctrl_q.egs;

  // Next value of every control bit, forces last so they win
  always_comb begin
    ctrl_d = ctrl_q;
    // Software requests
    if (wr_ctrl) begin
      if (sw_sel & ~ctrl_q.clk_sel & sel_set_ok) begin
        ctrl_d.clk_sel = 1'b1;
      end else if (~sw_sel & ctrl_q.clk_sel & sel_clr_ok) begin
        ctrl_d.clk_sel = 1'b0;
      end
      if (sw_igon) begin
        ctrl_d.igon = 1'b1;
      end else if (igon_clr_ok) begin
        ctrl_d.igon = 1'b0;
      end
      if (sw_egon) begin
        ctrl_d.egon = 1'b1;
      end else if (egon_clr_ok) begin
        ctrl_d.egon = 1'b0;
      end
      if (sw_mon & mon_set_ok) begin
        ctrl_d.mon_en = 1'b1;
      end else if (~sw_mon) begin
        ctrl_d.mon_en = 1'b0;
      end
    end
    // Forced select, external absence wins over internal
    if (int_lost | ~ctrl_q.igon) begin
      ctrl_d.clk_sel = 1'b1;
    end
    if (ext_lost | ~ctrl_q.egon) begin
      ctrl_d.clk_sel = 1'b0;
    end
    // Forced generator enables
    if (ctrl_q.mon_en | ~ctrl_q.clk_sel) begin
      ctrl_d.igon = 1'b1;
    end
    if (ctrl_q.mon_en | ctrl_q.clk_sel) begin
      ctrl_d.egon = 1'b1;
    end
    // Monitor needs both generators and no halt
    if (~ctrl_q.igon | ~ctrl_q.egon | halt) begin
      ctrl_d.mon_en = 1'b0;
    end
    // Internal stable after settling edges
    if (icnt_q == INT_SETTLE_EDGES) begin
      ctrl_d.igs = 1'b1;
    end
    if (igs_clr) begin
      ctrl_d.igs = 1'b0;
    end
    // External stable after start-up count
    ctrl_d.egs = (ecnt_q == EXT_START_CYCLES);
    if (ext_lost | ~ctrl_q.egon | halt) begin
      ctrl_d.egs = 1'b0;
    end
  end

  // Control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ----------------------------------------------------------------
  // Clock pin synchronisers and edge filters
  // ----------------------------------------------------------------

  // Three flops per pin; level changes when stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      isync_q <= 3'h0;
      esync_q <= 3'h0;
      ilev_q <= 1'b0;
      elev_q <= 1'b0;
    end else begin
      isync_q <= {isync_q[1:0], internal_clock_i};
      esync_q <= {esync_q[1:0], external_clock_i};
      if (isync_q[2] == isync_q[1]) begin
        ilev_q <= isync_q[1];
      end
      if (esync_q[2] == esync_q[1]) begin
        elev_q <= esync_q[1];
      end
    end
  end

  // Inactivity timers, restarted by each rising edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      iidle_q <= 8'h00;
      eidle_q <= 8'h00;
    end else begin
      if (iedge) begin
        iidle_q <= 8'h00;
      end else if (!iidle) begin
        iidle_q <= iidle_q + 8'h01;
      end
      if (eedge) begin
        eidle_q <= 8'h00;
      end else if (!eidle) begin
        eidle_q <= eidle_q + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Stability counters
  // ----------------------------------------------------------------

  // Internal settle count restarts whenever stable is forced low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      icnt_q <= 5'h00;
    end else if (igs_clr) begin
      icnt_q <= 5'h00;
    end else if (iedge && icnt_q != INT_SETTLE_EDGES) begin
      icnt_q <= icnt_q + 5'h01;
    end
  end

  // External start-up count of external clock cycles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ecnt_q <= 13'h0000;
    end else if (~ctrl_q.egon | halt | ext_lost) begin
      ecnt_q <= 13'h0000;
    end else if (eedge && ecnt_q != EXT_START_CYCLES) begin
      ecnt_q <= ecnt_q + 13'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Oscillator settings
  // ----------------------------------------------------------------

  // Multiplier and trim, locked while the monitor runs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mult_q <= MULT_RST;
      trim_q <= TRIM_RST;
      run_stop_q <= 1'b0;
    end else begin
      if (wr_mult && !ctrl_q.mon_en) begin
        mult_q <= wdat[6:0];
      end
      if (wr_trim && !ctrl_q.mon_en) begin
        trim_q <= wdat;
      end
      if (wr_opt) begin
        run_stop_q <= wdat[BIT_RUN_STOP];
      end
    end
  end

  // Divider and stage keep running through reset
  always_ff @(posedge clk_i) begin
    if (ctrl_q.igon) begin
      div_q <= loop_div_i;
      stage_q <= loop_stage_i;
    end else begin
      if (wr_div) begin
        div_q <= wdat[3:0];
      end
      if (wr_stage) begin
        stage_q <= wdat;
      end
    end
  end

  // Effective settings to the oscillator
  assign osc_cfg_o = '{
    mult: eff_mult(mult_q),
    trim: trim_q,
    divider: eff_div(div_q),
    stage: stage_q
  };
  assign internal_enable_o = ctrl_q.igon & ~halt;
  assign external_enable_o = ctrl_q.egon & ~halt;
  assign clocks_halt_o = halt;

  // ----------------------------------------------------------------
  // Output clock select
  // ----------------------------------------------------------------

  // Registered mux of the filtered levels, held low in halt
  always_ff @(posedge clk_i) begin
    if (rst_i || halt) begin
      out_clk_q <= 1'b0;
    end else if (ctrl_q.clk_sel) begin
      out_clk_q <= elev_q;
    end else begin
      out_clk_q <= ilev_q;
    end
  end
  assign osc_output_clock_o = out_clk_q;

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  wire [7:0] ctrl_rd = {2'b00, ctrl_q};
  wire [7:0] rd_mux =
    (adr_i == ADDR_CONTROL) ? ctrl_rd :
    (adr_i == ADDR_MULT) ? {1'b0, mult_q} :
    (adr_i == ADDR_TRIM) ? trim_q :
    (adr_i == ADDR_DIVIDER) ? {4'h0, div_q} :
    (adr_i == ADDR_STAGE) ? stage_q :
    (adr_i == ADDR_OPTION) ? {7'h00, run_stop_q} : 8'h00;

  // One-cycle ack, one cycle after the request appears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req & ~ack_q;
      rdat_q <= {24'h00_0000, rd_mux};
    end
  end
  assign ack_o = ack_q;
  assign dat_o = rdat_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_sel_ext_loss: assert property (@(posedge clk_i) disable iff (rst_i)
    (ext_lost | ~ctrl_q.egon) |=> !ctrl_q.clk_sel)
    else $error("select not cleared on external loss");
  a_sel_int_loss: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_q.egon & ~ext_lost & int_lost) |=> ctrl_q.clk_sel)
    else $error("select not set on internal loss");
  a_sel_rise_guard: assert property (@(posedge clk_i)
    disable iff (rst_i)
    $rose(ctrl_q.clk_sel) |-> $past(sel_set_ok | int_lost
    | ~ctrl_q.igon))
    else $error("select rose without external ready");
  a_igon_held: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_q.mon_en | ~ctrl_q.clk_sel) |=> ctrl_q.igon)
    else $error("internal generator dropped");
  a_egon_held: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_q.mon_en | ctrl_q.clk_sel) |=> ctrl_q.egon)
    else $error("external generator dropped");
  a_reset_values: assert property (@(posedge clk_i)
    rst_i |=> (ctrl_q == CTRL_RST && mult_q == MULT_RST
    && trim_q == TRIM_RST))
    else $error("reset values wrong");
  a_mult_locked: assert property (@(posedge clk_i) disable iff (rst_i)
    ((wr_mult | wr_trim) & ctrl_q.mon_en) |=>
    ($stable(mult_q) && $stable(trim_q)))
    else $error("locked setting was written");
  a_igs_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_mult | wr_trim) |=> !ctrl_q.igs ##1 !ctrl_q.igs)
    else $error("internal stable survived a write");
  a_egs_count: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_q.egs |-> $past(ecnt_q) == EXT_START_CYCLES)
    else $error("external stable before start-up count");
  a_halt_low: assert property (@(posedge clk_i) disable iff (rst_i)
    halt |=> !osc_output_clock_o)
    else $error("output clock ran in stop");
  a_stage_loop: assert property (@(posedge clk_i)
    ctrl_q.igon |=> stage_q == $past(loop_stage_i))
    else $error("stage not following loop filter");

endmodule

//--- test/clock_gen_select_control_tb.sv
// Self-checking bench for the clock generator control block.
// Assumes clk_gen_pkg and clk_gen_ctrl are compiled first; the bench
// plays Wishbone master and makes both slow oscillator clocks.
`timescale 1ns/10ps
module clock_gen_select_control_tb;
  import clk_gen_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_i = 1'b0; // Bus clock
  logic rst_i = 1'b1; // Reset
  logic cyc_i, stb_i, we_i; // Bus strobes
  logic [7:0] adr_i; // Bus address
  logic [3:0] sel_i; // Bus byte selects
  logic [31:0] dat_i, dat_o; // Bus data
  logic ack_o, internal_clock_i, external_clock_i, stop_i; // Misc
  logic [3:0] loop_div_i; // Loop divider
  logic [7:0] loop_stage_i; // Loop stage
  logic osc_output_clock_o, clocks_halt_o; // Clock outputs
  logic internal_enable_o, external_enable_o; // Enables
  osc_cfg_type osc_cfg_o; // Oscillator settings
  logic int_run, ext_run; // Oscillator clocks toggle when set
  int cnt = 0; // Free cycle counter
  int n_errors = 0; // Mismatches
  int checks = 0; // Comparisons
  logic [31:0] rd; // Last read data
  // ----------------------------------------------------------------
  // Clocks and device
  // ----------------------------------------------------------------
  always #20 clk_i = ~clk_i;
  // Half periods of 4 and 5 bus cycles, far slower than the bus
  always @(posedge clk_i) begin
    cnt <= cnt + 1;
    if (int_run && cnt % 4 == 0) internal_clock_i <= ~internal_clock_i;
    if (ext_run && cnt % 5 == 0) external_clock_i <= ~external_clock_i;
  end
  clk_gen_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .internal_clock_i(internal_clock_i),
    .external_clock_i(external_clock_i), .stop_i(stop_i),
    .loop_div_i(loop_div_i), .loop_stage_i(loop_stage_i),
    .osc_output_clock_o(osc_output_clock_o),
    .clocks_halt_o(clocks_halt_o), .internal_enable_o(internal_enable_o),
    .external_enable_o(external_enable_o), .osc_cfg_o(osc_cfg_o));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Control byte from its writable bits
  function automatic logic [7:0] ctl(logic m, logic s, logic i, logic e);
    ctl = 8'h00;
    ctl[BIT_MON] = m;
    ctl[BIT_SEL] = s;
    ctl[BIT_IGON] = i;
    ctl[BIT_EGON] = e;
  endfunction
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // One classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    sel_i <= 4'hf;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  // Control read and one bit compare
  task automatic cbit(input int b, input logic v, input string msg);
    wb(1'b0, ADDR_CONTROL, 8'h00);
    chk(rd[b], v, msg);
  endtask
  // Poll a control bit until it reaches the value, bounded
  task automatic wait_bit(input int b, input logic v, input int lim);
    int n;
    n = 0;
    do begin
      wb(1'b0, ADDR_CONTROL, 8'h00);
      n++;
    end while (rd[b] !== v && n < lim);
    chk(rd[b], v, "status bit wait");
  endtask
  // Source of the output clock, seen with the source held still
  task automatic route(input logic ext);
    if (ext) ext_run <= 1'b0;
    else int_run <= 1'b0;
    repeat (10) @(posedge clk_i);
    chk(osc_output_clock_o, ext ? external_clock_i : internal_clock_i,
        "output clock source");
    int_run <= 1'b1;
    ext_run <= 1'b1;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values();
    wb(1'b0, ADDR_CONTROL, 8'h00);
    chk(rd, {24'h0, ctl(0, 0, 1, 0)}, "control reset");
    wb(1'b0, ADDR_MULT, 8'h00);
    chk(rd, {25'h0, MULT_RST}, "mult reset");
    wb(1'b0, ADDR_TRIM, 8'h00);
    chk(rd, {24'h0, TRIM_RST}, "trim reset");
    wb(1'b1, 8'h20, 8'hff);
    wb(1'b0, 8'h20, 8'h00);
    chk(rd, 32'h0, "unmapped read");
    chk(osc_cfg_o.divider, DIV_MAX, "divider follows loop");
  endtask
  task automatic t_settings();
    wb(1'b1, ADDR_MULT, 8'h00);
    @(posedge clk_i);
    chk(osc_cfg_o.mult, 7'h01, "mult zero as one");
    wb(1'b1, ADDR_MULT, 8'h2a);
    wb(1'b0, ADDR_MULT, 8'h00);
    chk(rd, 32'h2a, "mult readback");
    wb(1'b1, ADDR_TRIM, 8'h7f);
    wb(1'b0, ADDR_TRIM, 8'h00);
    chk(rd, 32'h7f, "trim readback");
    wb(1'b1, ADDR_STAGE, 8'h11);
    @(posedge clk_i);
    chk(osc_cfg_o.stage, 8'h5a, "stage write blocked");
    wb(1'b1, ADDR_DIVIDER, 8'h03);
    @(posedge clk_i);
    chk(osc_cfg_o.divider, DIV_MAX, "divider loop driven");
  endtask
  task automatic t_int_stable();
    wait_bit(BIT_IGS, 1'b1, 150);
    wb(1'b1, ADDR_TRIM, 8'h80);
    cbit(BIT_IGS, 1'b0, "trim write clears stable");
    wait_bit(BIT_IGS, 1'b1, 150);
  endtask
  task automatic t_select();
    wb(1'b1, ADDR_CONTROL, ctl(0, 1, 1, 0));
    cbit(BIT_SEL, 1'b0, "select without external");
    route(1'b0);
    wb(1'b1, ADDR_CONTROL, ctl(0, 0, 1, 1));
    cbit(BIT_EGS, 1'b0, "external stable early");
    repeat (39000) @(posedge clk_i);
    cbit(BIT_EGS, 1'b0, "external stable before count");
    wait_bit(BIT_EGS, 1'b1, 1000);
    wb(1'b1, ADDR_CONTROL, ctl(0, 1, 1, 1));
    cbit(BIT_SEL, 1'b1, "select set");
    route(1'b1);
    wb(1'b1, ADDR_CONTROL, ctl(0, 1, 1, 0));
    cbit(BIT_EGON, 1'b1, "external on held by select");
    wb(1'b1, ADDR_CONTROL, ctl(0, 1, 0, 1));
    cbit(BIT_IGON, 1'b0, "internal off accepted");
    chk(rd[BIT_IGS], 1'b0, "internal off clears stable");
    chk(internal_enable_o, 1'b0, "internal enable off");
    wb(1'b1, ADDR_CONTROL, ctl(0, 0, 0, 1));
    cbit(BIT_SEL, 1'b1, "select held, internal off");
    wb(1'b1, ADDR_CONTROL, ctl(0, 1, 1, 1));
    wait_bit(BIT_IGS, 1'b1, 150);
    wb(1'b1, ADDR_CONTROL, ctl(0, 0, 1, 1));
    cbit(BIT_SEL, 1'b0, "select cleared");
  endtask
  task automatic t_monitor();
    wb(1'b1, ADDR_CONTROL, ctl(1, 0, 1, 1));
    cbit(BIT_MON, 1'b1, "monitor on");
    wb(1'b1, ADDR_MULT, 8'h07);
    wb(1'b0, ADDR_MULT, 8'h00);
    chk(rd, 32'h2a, "mult write blocked");
    wb(1'b1, ADDR_CONTROL, ctl(1, 0, 0, 0));
    cbit(BIT_IGON, 1'b1, "internal on held");
    chk(rd[BIT_EGON], 1'b1, "external on held");
    // Internal clock goes quiet: the monitor must move to external
    int_run <= 1'b0;
    repeat (80) @(posedge clk_i);
    cbit(BIT_SEL, 1'b1, "internal loss sets select");
    int_run <= 1'b1;
    ext_run <= 1'b0;
    repeat (80) @(posedge clk_i);
    cbit(BIT_EGS, 1'b0, "external loss clears stable");
    chk(rd[BIT_SEL], 1'b0, "external loss select");
    ext_run <= 1'b1;
    wb(1'b1, ADDR_CONTROL, ctl(0, 0, 1, 1));
    wb(1'b1, ADDR_CONTROL, ctl(0, 0, 1, 0));
    cbit(BIT_EGON, 1'b0, "external off accepted");
    chk(external_enable_o, 1'b0, "external enable off");
  endtask
  task automatic t_stop();
    wait_bit(BIT_IGS, 1'b1, 150);
    stop_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk(clocks_halt_o, 1'b1, "halt in stop");
    chk(osc_output_clock_o, 1'b0, "output low in stop");
    chk(internal_enable_o, 1'b0, "generator off in stop");
    cbit(BIT_IGS, 1'b0, "stop clears stable");
    wb(1'b1, ADDR_OPTION, 8'h01);
    @(posedge clk_i);
    chk(clocks_halt_o, 1'b0, "run in stop");
    stop_i <= 1'b0;
    wb(1'b1, ADDR_OPTION, 8'h00);
  endtask
  // ----------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Run needs about 42000 cycles
  initial begin
    repeat (60000) @(posedge clk_i);
    n_errors++;
    $display("ERROR %0t watchdog expired", $time);
    test_done();
  end
  initial begin
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 8'h00;
    sel_i = 4'h0;
    dat_i = 32'h0;
    internal_clock_i = 1'b0;
    external_clock_i = 1'b0;
    stop_i = 1'b0;
    loop_div_i = 4'hb;
    loop_stage_i = 8'h5a;
    int_run = 1'b1;
    ext_run = 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_values();
    t_settings();
    t_int_stable();
    t_select();
    t_monitor();
    t_stop();
    test_done();
  end
endmodule
